// File: design/rsi_reset_state_init.sv
// Overview of operation
// - Small variant loads vector byte 0 low 4 bits to PC[11:8], byte 1 to PC[7:0].
// - Large variants load vector byte 0 low 5 bits to PC[12:8], byte 1 to PC[7:0].
// - Vector byte 0 bit 6 sets register bank enable, bit 7 memory bank enable.
// - Reset in standby keeps carry, memory, registers, shift register, bit buffer.
// - Reset while running leaves those plus stack pointer undefined; nothing relies on them.
// - Every reset clears the three skip flags.
// - Every reset clears both interrupt nesting status flags.
// - Every reset sets the stack bank select to binary 1000.
// - Every reset clears memory bank select and register bank select.
// - Every reset clears all interrupt request flags.
// - Every reset clears all interrupt enable flags.
// - Every reset clears the interrupt priority select register.
// - Every reset clears the three edge mode registers.
// - Every reset clears the processor clock control register.
// - Every reset clears the system clock control register.
// - Every reset clears the clock output mode register.
// - Every reset clears the serial operation mode register.
// - Every reset clears the serial bus control register.
// - Every reset clears both port direction group registers.
// - Every reset clears the pull-up setting register.
// - Internal reset rises when the reset pin or watchdog reset is asserted.
// - After pin reset release, wait 2^17 or 2^15 clocks before execution.
module rsi_reset_state_init
  import rsi_pkg::*;
#(
  parameter bit PROG_MEM_LARGE   = 1'b1,
  parameter bit LONG_WAIT_SEL    = 1'b1,
  parameter int WAIT_LONG_CYCLES = WAIT_LONG_CYC,
  parameter int WAIT_SHORT_CYCLES = WAIT_SHORT_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        resetPinN,
  input  wire logic        wdtReset,
  input  wire logic        standbyMode,
  input  wire logic [7:0]  irqSet,
  input  wire logic [7:0]  romData,
  output logic      [12:0] romAddr,
  output logic             internalReset,
  output logic             cpuRun,
  output logic      [12:0] programCounter,
  output logic             memBankEnable,
  output logic             regBankEnable,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Wait length is fixed at build time by the oscillator option.
  localparam int          WAIT_CYCLES =
    LONG_WAIT_SEL ? WAIT_LONG_CYCLES : WAIT_SHORT_CYCLES;
  localparam logic [17:0] WAIT_LOAD   = 18'(WAIT_CYCLES - 1);

  // The whole block state.
  typedef struct packed {
    rsi_phase_type phase;
    logic [17:0]   waitCnt;
    logic          pinSync1;
    logic          pinSync2;
    logic          srcWdt;
    logic          lastStandby;
    logic          cpuRun;
    logic          intReset;
    logic [12:0]   romAddr;
    logic [7:0]    vecHi;
    logic [12:0]   programCounter;
    logic          carryFlag;
    logic [2:0]    skipFlags;
    logic          intNestStatusLo;
    logic          intNestStatusHi;
    logic          memBankEnable;
    logic          regBankEnable;
    logic [3:0]    stackBankSelect;
    logic [3:0]    memBankSelect;
    logic [3:0]    regBankSelect;
    logic [7:0]    intRequestFlags;
    logic [7:0]    intEnableFlags;
    logic [3:0]    intPrioritySelect;
    logic [3:0]    edgeMode0;
    logic [3:0]    edgeMode1;
    logic [3:0]    edgeMode2;
    logic [3:0]    cpuClockCtrl;
    logic [3:0]    sysClockCtrl;
    logic [3:0]    clockOutMode;
    logic [7:0]    serialOpMode;
    logic [7:0]    serialBusCtrl;
    logic [7:0]    serialShiftReg;
    logic [7:0]    portDirGroupA;
    logic [7:0]    portDirGroupB;
    logic [7:0]    pullupSetting;
    logic [7:0]    stackPointer;
    logic [15:0]   bitSeqBuffer;
    logic          awRdy;
    logic          awHave;
    logic [7:0]    awAddr;
    logic          wRdy;
    logic          wHave;
    logic [31:0]   wData;
    logic [3:0]    wStrb;
    logic          bVld;
    logic [1:0]    bResp;
    logic          arRdy;
    logic          rVld;
    logic [31:0]   rData;
    logic [1:0]    rResp;
  } rsi_state_type;

  // Power-on value; the pin synchroniser starts asserted so power-on
  // runs through the full settle wait like a pin reset.
  localparam rsi_state_type ST_RESET = '{
    phase:           PH_APPLY,
    intReset:        1'b1,
    stackBankSelect: SBS_RESET,
    awRdy:           1'b1,
    wRdy:            1'b1,
    arRdy:           1'b1,
    default:         '0
  };

  rsi_state_type st_r;
  rsi_state_type st_nxt;
  logic          extReq;
  logic          resetReq;
  logic [32:0]   rdWord;
  logic [32:0]   wrOld;
  logic [31:0]   wrWord;

  // Read decode: bit 32 flags a mapped offset.
  function automatic logic [32:0] readReg(input rsi_state_type s,
                                          input logic [7:0]    a);
    logic [32:0] r;
    r = 33'h000000000;
    case (a)
      ADDR_STATUS: r = {1'b1, 24'h000000, 1'b0, s.lastStandby,
                        s.srcWdt, s.cpuRun, 1'b0, s.phase};
      ADDR_PC:     r = {1'b1, 19'h00000, s.programCounter};
      ADDR_PSW:    r = {1'b1, 24'h000000, s.memBankEnable,
                        s.regBankEnable, s.intNestStatusHi,
                        s.intNestStatusLo, s.skipFlags, s.carryFlag};
      ADDR_BANK:   r = {1'b1, 20'h00000, s.regBankSelect,
                        s.memBankSelect, s.stackBankSelect};
      ADDR_IRQ:    r = {1'b1, 24'h000000, s.intRequestFlags};
      ADDR_IE:     r = {1'b1, 24'h000000, s.intEnableFlags};
      ADDR_IPS:    r = {1'b1, 28'h0000000, s.intPrioritySelect};
      ADDR_EDGE:   r = {1'b1, 20'h00000, s.edgeMode2, s.edgeMode1,
                        s.edgeMode0};
      ADDR_CLOCK:  r = {1'b1, 20'h00000, s.clockOutMode,
                        s.sysClockCtrl, s.cpuClockCtrl};
      ADDR_SERIAL: r = {1'b1, 8'h00, s.serialShiftReg,
                        s.serialBusCtrl, s.serialOpMode};
      ADDR_PORT:   r = {1'b1, 8'h00, s.pullupSetting,
                        s.portDirGroupB, s.portDirGroupA};
      ADDR_BSB:    r = {1'b1, 16'h0000, s.bitSeqBuffer};
      ADDR_SP:     r = {1'b1, 24'h000000, s.stackPointer};
      default:     r = 33'h000000000;
    endcase
    return r;
  endfunction

  // Byte-lane merge for partial writes.
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = d[8*i +: 8];
      end
    end
    return m;
  endfunction

  // Next-state logic for the sequencer, registers and bus slave.
  always_comb begin
    st_nxt   = st_r;
    rdWord   = readReg(st_r, s_axi_araddr);
    wrOld    = readReg(st_r, st_r.awAddr);
    wrWord   = mergeBytes(wrOld[31:0], st_r.wData, st_r.wStrb);
    // Only the second stage of the pin synchroniser is looked at.
    st_nxt.pinSync1 = resetPinN;
    st_nxt.pinSync2 = st_r.pinSync1;
    extReq   = ~st_r.pinSync2;
    resetReq = extReq | wdtReset;

    // Write address and data are taken independently, in either order.
    if (s_axi_awvalid && st_r.awRdy) begin
      st_nxt.awRdy  = 1'b0;
      st_nxt.awHave = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wRdy) begin
      st_nxt.wRdy  = 1'b0;
      st_nxt.wHave = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end

    // Perform the write once both halves are held.
    if (st_r.awHave && st_r.wHave && !st_r.bVld) begin
      st_nxt.bVld  = 1'b1;
      st_nxt.bResp = RESP_OKAY;
      case (st_r.awAddr)
        ADDR_STATUS, ADDR_PC: st_nxt.bResp = RESP_OKAY;
        ADDR_PSW: begin
          st_nxt.carryFlag       = wrWord[0];
          st_nxt.skipFlags       = wrWord[3:1];
          st_nxt.intNestStatusLo = wrWord[4];
          st_nxt.intNestStatusHi = wrWord[5];
          st_nxt.regBankEnable   = wrWord[6];
          st_nxt.memBankEnable   = wrWord[7];
        end
        ADDR_BANK: begin
          st_nxt.stackBankSelect = wrWord[3:0];
          st_nxt.memBankSelect   = wrWord[7:4];
          st_nxt.regBankSelect   = wrWord[11:8];
        end
        ADDR_IRQ:  st_nxt.intRequestFlags   = wrWord[7:0];
        ADDR_IE:   st_nxt.intEnableFlags    = wrWord[7:0];
        ADDR_IPS:  st_nxt.intPrioritySelect = wrWord[3:0];
        ADDR_EDGE: begin
          st_nxt.edgeMode0 = wrWord[3:0];
          st_nxt.edgeMode1 = wrWord[7:4];
          st_nxt.edgeMode2 = wrWord[11:8];
        end
        ADDR_CLOCK: begin
          st_nxt.cpuClockCtrl = wrWord[3:0];
          st_nxt.sysClockCtrl = wrWord[7:4];
          st_nxt.clockOutMode = wrWord[11:8];
        end
        ADDR_SERIAL: begin
          st_nxt.serialOpMode   = wrWord[7:0];
          st_nxt.serialBusCtrl  = wrWord[15:8];
          st_nxt.serialShiftReg = wrWord[23:16];
        end
        ADDR_PORT: begin
          st_nxt.portDirGroupA = wrWord[7:0];
          st_nxt.portDirGroupB = wrWord[15:8];
          st_nxt.pullupSetting = wrWord[23:16];
        end
        ADDR_BSB: st_nxt.bitSeqBuffer = wrWord[15:0];
        ADDR_SP:  st_nxt.stackPointer = wrWord[7:0];
        default:  st_nxt.bResp = RESP_SLVERR;
      endcase
    end

    // Release the write channels when the response is taken.
    if (st_r.bVld && s_axi_bready) begin
      st_nxt.bVld   = 1'b0;
      st_nxt.awHave = 1'b0;
      st_nxt.wHave  = 1'b0;
      st_nxt.awRdy  = 1'b1;
      st_nxt.wRdy   = 1'b1;
    end

    // Reads answer one cycle after the address is taken.
    if (s_axi_arvalid && st_r.arRdy) begin
      st_nxt.arRdy = 1'b0;
      st_nxt.rVld  = 1'b1;
      st_nxt.rData = rdWord[31:0];
      st_nxt.rResp = rdWord[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.rVld && s_axi_rready) begin
      st_nxt.rVld  = 1'b0;
      st_nxt.arRdy = 1'b1;
    end

    // Hardware request events are ORed in after the software write,
    // so a set arriving with a clear is not lost.
    st_nxt.intRequestFlags = st_nxt.intRequestFlags | irqSet;

    // Reset sequencer.
    case (st_r.phase)
      PH_RUN: begin
        if (resetReq) begin
          st_nxt.phase       = PH_APPLY;
          st_nxt.lastStandby = standbyMode;
          st_nxt.srcWdt      = ~extReq;
        end
      end
      PH_APPLY: begin
        // A pin reset seen at any time during the hold forces the wait.
        if (extReq) begin
          st_nxt.srcWdt = 1'b0;
        end
        if (!resetReq) begin
          if (st_r.srcWdt) begin
            st_nxt.phase = PH_FETCH_HI;
          end else begin
            st_nxt.phase   = PH_WAIT;
            st_nxt.waitCnt = WAIT_LOAD;
          end
        end
      end
      PH_WAIT: begin
        if (resetReq) begin
          st_nxt.phase = PH_APPLY;
        end else if (st_r.waitCnt == 18'h00000) begin
          st_nxt.phase = PH_FETCH_HI;
        end else begin
          st_nxt.waitCnt = st_r.waitCnt - 18'h00001;
        end
      end
      PH_FETCH_HI: begin
        if (resetReq) begin
          st_nxt.phase = PH_APPLY;
        end else begin
          st_nxt.vecHi   = romData;
          st_nxt.romAddr = VEC_LO_ADDR;
          st_nxt.phase   = PH_FETCH_LO;
        end
      end
      PH_FETCH_LO: begin
        if (resetReq) begin
          st_nxt.phase = PH_APPLY;
        end else begin
          if (PROG_MEM_LARGE) begin
            st_nxt.programCounter = {st_r.vecHi[4:0], romData};
          end else begin
            st_nxt.programCounter = {1'b0, st_r.vecHi[3:0], romData};
          end
          st_nxt.regBankEnable = st_r.vecHi[VEC_RBE_BIT];
          st_nxt.memBankEnable = st_r.vecHi[VEC_MBE_BIT];
          st_nxt.phase         = PH_RUN;
        end
      end
      default: st_nxt.phase = PH_APPLY;
    endcase

    // All reset values land together while the apply phase holds.
    // Software writes, except to the two bank enable bits, and request events in that window are overridden.
    if (st_nxt.phase == PH_APPLY) begin
      st_nxt.romAddr           = VEC_HI_ADDR;
      st_nxt.skipFlags         = 3'h0;
      st_nxt.intNestStatusLo   = 1'b0;
      st_nxt.intNestStatusHi   = 1'b0;
      st_nxt.stackBankSelect   = SBS_RESET;
      st_nxt.memBankSelect     = ZERO4;
      st_nxt.regBankSelect     = ZERO4;
      st_nxt.intRequestFlags   = ZERO8;
      st_nxt.intEnableFlags    = ZERO8;
      st_nxt.intPrioritySelect = ZERO4;
      st_nxt.edgeMode0         = ZERO4;
      st_nxt.edgeMode1         = ZERO4;
      st_nxt.edgeMode2         = ZERO4;
      st_nxt.cpuClockCtrl      = ZERO4;
      st_nxt.sysClockCtrl      = ZERO4;
      st_nxt.clockOutMode      = ZERO4;
      st_nxt.serialOpMode      = ZERO8;
      st_nxt.serialBusCtrl     = ZERO8;
      st_nxt.portDirGroupA     = ZERO8;
      st_nxt.portDirGroupB     = ZERO8;
      st_nxt.pullupSetting     = ZERO8;
      // Carry, shift register, bit buffer and stack pointer are left
      // alone, which keeps them in standby; software may not trust
      // them after a reset taken while running.
      st_nxt.carryFlag         = st_r.carryFlag;
      st_nxt.serialShiftReg    = st_r.serialShiftReg;
      st_nxt.bitSeqBuffer      = st_r.bitSeqBuffer;
      st_nxt.stackPointer      = st_r.stackPointer;
    end

    // Status outputs are registered from the next phase.
    st_nxt.intReset = (st_nxt.phase != PH_RUN);
    st_nxt.cpuRun   = (st_nxt.phase == PH_RUN);
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output is a field of the state register.
  assign romAddr        = st_r.romAddr;
  assign internalReset  = st_r.intReset;
  assign cpuRun         = st_r.cpuRun;
  assign programCounter = st_r.programCounter;
  assign memBankEnable  = st_r.memBankEnable;
  assign regBankEnable  = st_r.regBankEnable;
  assign s_axi_awready  = st_r.awRdy;
  assign s_axi_wready   = st_r.wRdy;
  assign s_axi_bvalid   = st_r.bVld;
  assign s_axi_bresp    = st_r.bResp;
  assign s_axi_arready  = st_r.arRdy;
  assign s_axi_rvalid   = st_r.rVld;
  assign s_axi_rdata    = st_r.rData;
  assign s_axi_rresp    = st_r.rResp;

endmodule

// File: design/rsi_pkg.sv
package rsi_pkg;

  // Sequencer phases; the core runs only in PH_RUN.
  typedef enum logic [2:0] {
    PH_RUN      = 3'b000,
    PH_APPLY    = 3'b001,
    PH_WAIT     = 3'b010,
    PH_FETCH_HI = 3'b011,
    PH_FETCH_LO = 3'b100
  } rsi_phase_type;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_PC     = 8'h04;
  localparam logic [7:0] ADDR_PSW    = 8'h08;
  localparam logic [7:0] ADDR_BANK   = 8'h0C;
  localparam logic [7:0] ADDR_IRQ    = 8'h10;
  localparam logic [7:0] ADDR_IE     = 8'h14;
  localparam logic [7:0] ADDR_IPS    = 8'h18;
  localparam logic [7:0] ADDR_EDGE   = 8'h1C;
  localparam logic [7:0] ADDR_CLOCK  = 8'h20;
  localparam logic [7:0] ADDR_SERIAL = 8'h24;
  localparam logic [7:0] ADDR_PORT   = 8'h28;
  localparam logic [7:0] ADDR_BSB    = 8'h2C;
  localparam logic [7:0] ADDR_SP     = 8'h30;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset vector locations and field positions in the first vector byte.
  localparam logic [12:0] VEC_HI_ADDR = 13'h0000;
  localparam logic [12:0] VEC_LO_ADDR = 13'h0001;
  localparam int          VEC_RBE_BIT = 6;
  localparam int          VEC_MBE_BIT = 7;

  // Reset values of the control registers.
  localparam logic [3:0] SBS_RESET  = 4'h8;
  localparam logic [7:0] ZERO8      = 8'h00;
  localparam logic [3:0] ZERO4      = 4'h0;

  // Oscillation settle wait, in main clock periods, and the clk rate ratio.
  localparam int WAIT_LONG_FX  = 2 ** 17;
  localparam int WAIT_SHORT_FX = 2 ** 15;
  localparam int CLK_PER_FX    = 1;
  localparam int WAIT_LONG_CYC  = WAIT_LONG_FX * CLK_PER_FX;
  localparam int WAIT_SHORT_CYC = WAIT_SHORT_FX * CLK_PER_FX;

endpackage

// File: tb/rsi_reset_state_init_sva.sv
module rsi_reset_state_init_sva #(
  parameter bit PROG_MEM_LARGE = 1'b1
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        resetPinN,
  input wire logic        wdtReset,
  input wire logic [7:0]  romData,
  input wire logic [12:0] romAddr,
  input wire logic        internalReset,
  input wire logic        cpuRun,
  input wire logic [12:0] programCounter,
  input wire logic        memBankEnable,
  input wire logic        regBankEnable,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Keeps the last byte read at address zero, so the final load can be judged.
  logic [7:0] hiByte_r;
  always_ff @(posedge clk) begin
    if (romAddr == 13'h0000) begin
      hiByte_r <= romData;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_WDT_ENTER: assert property (wdtReset |=> internalReset && !cpuRun)
    else $error("watchdog request did not raise internal reset");
  AST_PIN_ENTER: assert property ($fell(resetPinN) |-> ##[1:3] internalReset)
    else $error("pin request did not raise internal reset");
  AST_FETCH_ORDER: assert property (internalReset && romAddr == 13'h0001 |->
    $past(romAddr) == 13'h0000) else $error("low vector byte fetched first");
  AST_VEC_LO: assert property (internalReset && romAddr == 13'h0001 && !wdtReset
    && $past(resetPinN, 2) |=> cpuRun && programCounter[7:0] == $past(romData))
    else $error("low pc byte wrong");
  AST_VEC_HI: assert property ($fell(internalReset) |->
    programCounter[12:8] == (PROG_MEM_LARGE ? hiByte_r[4:0] : {1'b0, hiByte_r[3:0]})
    && memBankEnable == hiByte_r[7]
    && regBankEnable == hiByte_r[6]) else $error("high pc bits or bank enables wrong");
  AST_RUN_AFTER_FETCH: assert property ($rose(cpuRun) |-> $past(romAddr) == 13'h0001)
    else $error("execution began before the vector fetch");
  AST_PC_HOLD: assert property (internalReset && romAddr == 13'h0000
    |=> $stable(programCounter)) else $error("pc moved before the vector fetch");
  AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
endmodule

bind rsi_reset_state_init rsi_reset_state_init_sva #(.PROG_MEM_LARGE(PROG_MEM_LARGE))
  i_rsi_reset_state_init_sva (
  .clk(clk), .reset_n(reset_n), .resetPinN(resetPinN), .wdtReset(wdtReset),
  .romData(romData), .romAddr(romAddr), .internalReset(internalReset), .cpuRun(cpuRun),
  .programCounter(programCounter), .memBankEnable(memBankEnable),
  .regBankEnable(regBankEnable), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp));

// File: tb/rsi_far_side.sv
module rsi_far_side (
  input  wire logic        clk,
  input  wire logic        pinReq,
  input  wire logic        wdtReq,
  input  wire logic [7:0]  vecHi,
  input  wire logic [7:0]  vecLo,
  input  wire logic [12:0] romAddr,
  output logic             resetPinN,
  output logic             wdtReset,
  output logic      [7:0]  romData
);
  timeunit 1ns;
  timeprecision 1ps;
  // The pin and the timer change only after an edge, as the real sources do.
  always_ff @(posedge clk) begin
    resetPinN <= !pinReq;
    wdtReset  <= wdtReq;
  end
  // Other addresses give a pattern, so a stray fetch cannot look right by chance.
  always_comb begin
    if (romAddr == 13'h0000) begin
      romData = vecHi;
    end else if (romAddr == 13'h0001) begin
      romData = vecLo;
    end else begin
      romData = romAddr[7:0] ^ 8'hA5;
    end
  end
endmodule

// File: tb/rsi_reset_state_init_tb_top.sv
module rsi_reset_state_init_tb_top;
  import rsi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAIT_L = 16;
  localparam int WAIT_S = 8;
  int errors;
  int cmp_count;
  logic clk, reset_n, pinReq, wdtReq, standbyMode, resetPinN, wdtReset;
  logic internalReset, cpuRun, memBankEnable, regBankEnable, cpuRunS;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] irqSet, vecHi, vecLo, romData, awaddr, araddr, romDataS;
  logic [12:0] romAddr, programCounter, romAddrS, pcS;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;

  rsi_reset_state_init #(.WAIT_LONG_CYCLES(WAIT_L), .WAIT_SHORT_CYCLES(WAIT_S))
    i_rsi_reset_state_init (.clk(clk), .reset_n(reset_n), .resetPinN(resetPinN),
    .wdtReset(wdtReset), .standbyMode(standbyMode), .irqSet(irqSet), .romData(romData),
    .romAddr(romAddr), .internalReset(internalReset), .cpuRun(cpuRun),
    .programCounter(programCounter), .memBankEnable(memBankEnable),
    .regBankEnable(regBankEnable), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  rsi_far_side i_rsi_far_side (.clk(clk), .pinReq(pinReq), .wdtReq(wdtReq), .vecHi(vecHi),
    .vecLo(vecLo), .romAddr(romAddr), .resetPinN(resetPinN), .wdtReset(wdtReset),
    .romData(romData));
  // Small-memory variant with the short wait.
  rsi_reset_state_init #(.PROG_MEM_LARGE(1'b0), .LONG_WAIT_SEL(1'b0),
    .WAIT_SHORT_CYCLES(WAIT_S)) i_rsi_reset_state_init_small (.clk(clk), .reset_n(reset_n),
    .resetPinN(resetPinN), .wdtReset(wdtReset), .standbyMode(standbyMode), .irqSet(irqSet),
    .romData(romDataS), .romAddr(romAddrS), .internalReset(), .cpuRun(cpuRunS),
    .programCounter(pcS), .memBankEnable(), .regBankEnable(), .s_axi_awaddr('0),
    .s_axi_awvalid('0), .s_axi_awready(), .s_axi_wdata('0), .s_axi_wstrb('0),
    .s_axi_wvalid('0), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready('0),
    .s_axi_araddr('0), .s_axi_arvalid('0), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
    .s_axi_rvalid(), .s_axi_rready('0));
  rsi_far_side i_rsi_far_side_small (.clk(clk), .pinReq(pinReq), .wdtReq(wdtReq),
    .vecHi(vecHi), .vecLo(vecLo), .romAddr(romAddrS), .resetPinN(), .wdtReset(),
    .romData(romDataS));

  // Free-running clock at 40 MHz.
  always #12.5 clk = !clk;

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Ready is sampled at the falling edge, where registered outputs are settled.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit awHit, wHit, bDone;
    int n;
    bDone = 0;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bDone && n < 100) begin
      @(negedge clk);
      awHit = awvalid && awready;
      wHit = wvalid && wready;
      bDone = bvalid;
      r = bresp;
      n++;
      @(posedge clk);
      if (awHit) awvalid <= 1'b0;
      if (wHit) wvalid <= 1'b0;
      if (bDone) bready <= 1'b0;
    end
    if (!bDone) errors++;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    bit arHit, rDone;
    int n;
    rDone = 0;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rDone && n < 100) begin
      @(negedge clk);
      arHit = arvalid && arready;
      rDone = rvalid;
      n++;
      @(posedge clk);
      if (arHit) arvalid <= 1'b0;
      if (rDone) rready <= 1'b0;
    end
    if (!rDone) errors++;
    check32(rdata, e, "read data");
    check32({30'h0, rresp}, {30'h0, er}, "read response");
  endtask

  // Counts cycles until the core runs again, bounded so a hang cannot stall here.
  task automatic wait_run(input int lo, input int hi);
    int cyc;
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (!cpuRun && cyc < 300);
    check32(32'(cyc >= lo && cyc <= hi), 32'h1, "reset wait length");
    check32({19'h0, programCounter}, {19'h0, vecHi[4:0], vecLo}, "vector pc");
    check32({30'h0, memBankEnable, regBankEnable}, {30'h0, vecHi[7:6]}, "bank enables");
  endtask

  task automatic test_power_on();
    int cyc;
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (!cpuRunS && cyc < 300);
    check32(32'(cyc >= WAIT_S && cyc <= WAIT_S + 7), 32'h1, "short wait");
    check32({19'h0, pcS}, {20'h0, vecHi[3:0], vecLo}, "small vector pc");
    wait_run(WAIT_L - cyc, WAIT_L + 7 - cyc);
    $display("test power_on done");
  endtask

  // Fill every writable register except the stack pointer, then a watchdog reset while in standby.
  task automatic test_standby_wdt();
    logic [7:0] adr [10] = '{ADDR_PSW, ADDR_BANK, ADDR_IRQ, ADDR_IE, ADDR_IPS, ADDR_EDGE,
                             ADDR_CLOCK, ADDR_SERIAL, ADDR_PORT, ADDR_BSB};
    logic [31:0] exp [10] = '{32'h41, 32'h8, 0, 0, 0, 0, 0, 32'hFF0000, 0, 32'hFFFF};
    logic [1:0] r;
    foreach (adr[i]) axi_write(adr[i], 32'hFFFFFFFF, r);
    vecHi <= 8'h4A;
    vecLo <= 8'hC3;
    standbyMode <= 1'b1;
    wdtReq <= 1'b1;
    @(posedge clk);
    wdtReq <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    standbyMode <= 1'b0;
    wait_run(1, 20);
    foreach (adr[i]) rd_chk(adr[i], exp[i], RESP_OKAY);
    $display("test standby_wdt done"); // in the same table.
  endtask

  // Pin reset while running: full wait, control registers back to reset values.
  task automatic test_pin_reset();
    logic [1:0] r;
    axi_write(ADDR_CLOCK, 32'hFFF, r);
    axi_write(ADDR_BANK, 32'h0, r);
    axi_write(ADDR_IE, 32'hFF, r);
    @(posedge clk);
    pinReq <= 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    check32({31'h0, internalReset}, 32'h1, "pin reset entry");
    @(posedge clk);
    pinReq <= 1'b0;
    wait_run(WAIT_L, WAIT_L + 10);
    rd_chk(ADDR_CLOCK, 32'h0, RESP_OKAY);
    rd_chk(ADDR_BANK, 32'h8, RESP_OKAY);
    rd_chk(ADDR_IE, 32'h0, RESP_OKAY);
    $display("test pin_reset done");
  endtask

  // Hardware request flags, then an unmapped place on the bus.
  task automatic test_irq_bus();
    logic [1:0] r;
    @(posedge clk);
    irqSet <= 8'h21;
    @(posedge clk);
    irqSet <= 8'h00;
    rd_chk(ADDR_IRQ, 32'h21, RESP_OKAY);
    rd_chk(8'h3C, 32'h0, RESP_SLVERR);
    axi_write(8'h40, 32'h1, r);
    check32({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write response");
    $display("test irq_bus done");
  endtask

  // Main sequence: three cycles of reset, then the scenarios in turn.
  initial begin
    errors = 0;
    cmp_count = 0;
    clk = 1'b0;
    reset_n = 1'b0;
    {pinReq, wdtReq, standbyMode, awvalid, wvalid, bready, arvalid, rready} = '0;
    irqSet = 8'h00;
    vecHi = 8'hD5;
    vecLo = 8'h3C;
    {awaddr, araddr, wdata} = '0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    test_power_on();
    test_standby_wdt();
    test_pin_reset();
    test_irq_bus();
    print_verdict();
  end

  // The run needs under two hundred cycles; this limit is far beyond that.
  initial begin
    #200us;
    $display("Error at %0t: watchdog expired", $time);
    errors++;
    print_verdict();
  end
endmodule
